/* ddh_axi_dev.sv */
`timescale 1ns/1ps
module ddh_axi_dev (
   // Clock and port reset
   input wire logic clk,
   input wire logic axi_aresetn,
   // Test controls
   input wire logic slow,
   input wire logic bad_id,
   input wire logic bad_last,
   input wire logic [1:0] resp,
   input wire logic [31:0] seed,
   input wire logic [31:0] strb,
   input wire logic [31:0] rbase,
   output int merr,
   // Write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [5:0] awid,
   input wire logic [7:0] awlen,
   input wire logic [1:0] awburst,
   input wire logic write_all_strobes_flag,
   input wire logic [511:0] wdata,
   input wire logic [63:0] wstrb,
   input wire logic wlast,
   input wire logic wvalid,
   output logic wready,
   // Write response
   output logic [5:0] bid,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read
   input wire logic arvalid,
   output logic arready,
   input wire logic [5:0] arid,
   input wire logic [7:0] arlen,
   output logic [511:0] rdata,
   output logic [5:0] rid,
   output logic rlast,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   logic [1:0] st;
   logic [7:0] len, beat;
   logic [5:0] id, tid;
   logic as, tgl, rh;
   wire go = !slow || tgl;
   assign tid = id ^ {5'h00, bad_id};
   assign awready = st == 2'd0 && go;
   assign arready = st == 2'd0 && go && !awvalid;
   assign wready = st == 2'd1 && go;
   assign bvalid = st == 2'd2;
   assign rvalid = st == 2'd3 && (go || rh);
   assign bid = bvalid ? tid : ~id;
   assign rid = rvalid ? tid : ~id;
   assign bresp = bvalid ? resp : ~resp;
   assign rresp = rvalid ? resp : ~resp;
   assign rlast = rvalid && (beat == len || bad_last && beat == 8'h00);
   for (genvar j = 0; j < 16; j++) begin : g_w
      assign rdata[32*j +: 32] = rbase ^ {16'h0000, beat, 8'(j)} ^ {32{!rvalid}};
   end
   initial merr = 0;
   always @(posedge clk or negedge axi_aresetn) begin
      if (!axi_aresetn) begin
         st <= 2'd0;
         tgl <= 1'b0;
         rh <= 1'b0;
      end else begin
         tgl <= !tgl;
         rh <= rvalid && !rready;
         if (awvalid && awready) begin
            st <= 2'd1;
            len <= awlen;
            id <= awid;
            as <= write_all_strobes_flag;
            beat <= 8'h00;
            if (!awburst[0] == !awburst[1] || write_all_strobes_flag && awlen > 8'h0f)
               merr = merr + 1;
         end
         if (wvalid && wready) begin
            beat <= beat + 8'h01;
            if (wlast !== (beat == len))
               merr = merr + 1;
            if (wstrb !== (as ? {64{1'b1}} : {2{strb}}) || wdata !== {16{seed + {24'h0, beat}}})
               merr = merr + 1;
            if (beat == len)
               st <= 2'd2;
         end
         if (bvalid && bready)
            st <= 2'd0;
         if (arvalid && arready) begin
            st <= 2'd3;
            len <= arlen;
            id <= arid;
            beat <= 8'h00;
         end
         if (rvalid && rready) begin
            beat <= beat + 8'h01;
            if (rlast)
               st <= 2'd0;
         end
      end
   end
endmodule

/* ddh_axi_host.sv */
// Operation
// [RL1] Port reset output holds the AXI port in reset while low
// [RL2] Data buses are 512 bits, write strobes 64 bits, one per byte
// [RL3] Device tags each write response and read beat with the transaction ID
// [RL4] Burst type 01 is incrementing, 10 wrapping; other types are refused
// [RL5] A 33-bit start byte address is presented on each address channel
// [RL6] An 8-bit length and 3-bit size accompany each address
// [RL7] Device raises read-last only on the final read beat
// [RL8] Write-last is asserted on exactly the final write beat
// [RL9] All-strobes writes are limited to 16 beats
// [RL10] A QoS identifier accompanies every read and write address
// [RL11] Write response completes when valid and ready meet in one cycle
// [RL12] Read beat transfers when read-valid and read-ready meet
// [RL13] Device raises address-ready only when it can take the address
// [RL14] Device raises write-ready only when it can take the data
// [RL15] Device returns a 2-bit response on read and write responses
// [RL16] A lock-type bit accompanies both address channels
// [RL17] A 4-bit memory type accompanies every write address
// [RL18] Controller core clock runs at a quarter of the data rate
// [RL19] PHY clock runs at half the data rate
// [RL20] Valid and payload stay stable until the matching ready
// [RL21] Auto-precharge and coherent-bufferable requests travel per transaction
`timescale 1ns/1ps
`include "ddh_map.svh"
module ddh_axi_host #(
   parameter int DATA_W = 512,
   parameter int ID_W = 6
) (
   // System
   input wire logic clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire ddh_pkg::ddh_avaddr_t avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Clocks and port reset
   output logic controller_core_clock,
   output logic phy_half_rate_clock,
   output logic axi_aresetn,
   // Write address
   output ddh_pkg::ddh_axaddr_t awaddr,
   output logic [1:0] awburst,
   output logic [ID_W-1:0] awid,
   output logic [7:0] awlen,
   output logic [2:0] awsize,
   output logic awvalid,
   input wire logic awready,
   output logic awlock,
   output logic awqos,
   output logic [3:0] awcache,
   output logic write_autoprecharge_req,
   output logic write_all_strobes_flag,
   output logic write_coherent_bufferable_sel,
   // Write data
   output logic [DATA_W-1:0] wdata,
   output logic [DATA_W/8-1:0] wstrb,
   output logic wlast,
   output logic wvalid,
   input wire logic wready,
   // Write response
   input wire logic [ID_W-1:0] bid,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read address
   output ddh_pkg::ddh_axaddr_t araddr,
   output logic [1:0] arburst,
   output logic [ID_W-1:0] arid,
   output logic [7:0] arlen,
   output logic [2:0] arsize,
   output logic arvalid,
   input wire logic arready,
   output logic arlock,
   output logic arqos,
   output logic read_autoprecharge_req,
   // Read data
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [ID_W-1:0] rid,
   input wire logic rlast,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   import ddh_pkg::*;
   localparam int REP = DATA_W / 32;
   logic rs1, rst_n;
   logic [6:0] ctrl;
   logic [32:0] addr_q;
   logic [31:0] burst_q, seed, strb_q, rsum;
   logic busy_n, done, id_err, last_err, rej;
   logic [1:0] bresp_q, rresp_q;
   logic [ID_W-1:0] tag_q;
   logic [7:0] beat;
   logic div;
   ddh_state_t state, next_state;
   logic [31:0] fold;
   wire [6:0] cmd = {avs_writedata[6:2], 2'h0};
   // Reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rs1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1 <= 1'b1;
         rst_n <= rs1;
      end
   end

   // Bus decode
   wire acc = avs_write && !avs_waitrequest;
   wire w_ctrl = acc && avs_address == `DDH_CTRL;
   wire [7:0] len = burst_q[7:0];
   wire [1:0] btype = burst_q[13:12];
   wire bt_ok = btype == DDH_INCR || btype == DDH_WRAP; // [RL4]
   wire alls_ok = !cmd[`DDH_B_ALLS] || len <= `DDH_ALLS_MAXLEN; // [RL9]
   wire idle = state == DDH_IDLE && !ctrl[`DDH_B_PRST] && !cmd[`DDH_B_PRST];
   wire ask_wr = w_ctrl && avs_writedata[`DDH_B_WR];
   wire ask_rd = w_ctrl && avs_writedata[`DDH_B_RD] && !ask_wr;
   wire go_wr = ask_wr && idle && bt_ok && alls_ok;
   wire go_rd = ask_rd && idle && bt_ok;
   wire go = go_wr || go_rd;
   wire bad = (ask_wr || ask_rd) && idle && !go;
   wire aw_hs = awvalid && awready;
   wire w_hs = wvalid && wready;
   wire b_hs = bvalid && bready; // [RL11]
   wire ar_hs = arvalid && arready;
   wire r_hs = rvalid && rready; // [RL12]
   wire fin = (b_hs && state == DDH_WRESP) || (r_hs && rlast);
   wire [7:0] next_beat = go ? 8'h00 : (w_hs || r_hs) ? beat + 8'h01 : beat;
   wire [31:0] status = {13'h0, rej, last_err, id_err, 2'h0,
      tag_q, 2'h0, rresp_q, bresp_q, done, !busy_n};
   wire [31:0] rd_mux =
      avs_address == `DDH_CTRL ? {25'h0, ctrl} :
      avs_address == `DDH_ADDR_LO ? addr_q[31:0] :
      avs_address == `DDH_ADDR_HI ? {31'h0, addr_q[32]} :
      avs_address == `DDH_BURST ? burst_q :
      avs_address == `DDH_STATUS ? status :
      avs_address == `DDH_SEED ? seed :
      avs_address == `DDH_STRB ? strb_q :
      avs_address == `DDH_RSUM ? rsum : 32'h0;

   // One wait state per access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         avs_readdata <= rd_mux;
      end
   end

   // Software registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `DDH_CTRL_RST;
         addr_q <= 33'h0;
         burst_q <= `DDH_BURST_RST;
         seed <= 32'h0;
         strb_q <= 32'hffff_ffff;
      end else begin
         if (w_ctrl)
            ctrl <= cmd;
         if (acc && avs_address == `DDH_ADDR_LO)
            addr_q[31:0] <= avs_writedata;
         if (acc && avs_address == `DDH_ADDR_HI)
            addr_q[32] <= avs_writedata[0];
         if (acc && avs_address == `DDH_BURST)
            burst_q <= avs_writedata;
         if (acc && avs_address == `DDH_SEED)
            seed <= avs_writedata;
         if (acc && avs_address == `DDH_STRB)
            strb_q <= avs_writedata;
      end
   end

   // Clock dividers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 1'b0;
         phy_half_rate_clock <= 1'b0;
         controller_core_clock <= 1'b0;
         axi_aresetn <= 1'b0;
      end else begin
         div <= !div;
         phy_half_rate_clock <= !phy_half_rate_clock; // [RL19]
         if (div)
            controller_core_clock <= !controller_core_clock; // [RL18]
         axi_aresetn <= !ctrl[`DDH_B_PRST]; // [RL1]
      end
   end

   // Transaction sequencing
   always_comb begin
      case (state)
         DDH_IDLE: next_state = go_wr ? DDH_WADDR : go_rd ? DDH_RADDR : DDH_IDLE;
         DDH_WADDR: next_state = aw_hs ? DDH_WDATA : DDH_WADDR; // [RL20]
         DDH_WDATA: next_state = (w_hs && wlast) ? DDH_WRESP : DDH_WDATA;
         DDH_WRESP: next_state = b_hs ? DDH_IDLE : DDH_WRESP;
         DDH_RADDR: next_state = ar_hs ? DDH_RDATA : DDH_RADDR;
         DDH_RDATA: next_state = (r_hs && rlast) ? DDH_IDLE : DDH_RDATA;
         default: next_state = DDH_IDLE;
      endcase
   end

   always_comb begin
      fold = 32'h0;
      for (int i = 0; i < REP; i++)
         fold = fold ^ rdata[i*32 +: 32];
   end

   // Channel outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= DDH_IDLE;
         beat <= 8'h00;
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         wlast <= 1'b0;
         bready <= 1'b0;
         arvalid <= 1'b0;
         rready <= 1'b0;
         wdata <= '0;
      end else begin
         state <= next_state;
         beat <= next_beat;
         awvalid <= next_state == DDH_WADDR; // [RL20]
         wvalid <= next_state == DDH_WDATA;
         wlast <= next_state == DDH_WDATA && next_beat == len; // [RL8]
         wdata <= {REP{seed + {24'h0, next_beat}}}; // [RL2]
         bready <= next_state == DDH_WRESP;
         arvalid <= next_state == DDH_RADDR;
         rready <= next_state == DDH_RDATA;
      end
   end

   // Address fields captured at start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awaddr <= 33'h0;
         awlen <= 8'h00;
         awsize <= 3'h0;
         awburst <= DDH_INCR;
         awid <= '0;
         awqos <= 1'b0;
         awcache <= 4'h0;
         awlock <= 1'b0;
         write_autoprecharge_req <= 1'b0;
         write_all_strobes_flag <= 1'b0;
         write_coherent_bufferable_sel <= 1'b0;
         wstrb <= '0;
      end else if (go) begin
         awaddr <= addr_q; // [RL5]
         awlen <= len; // [RL6]
         awsize <= burst_q[10:8];
         awburst <= btype; // [RL4]
         awid <= burst_q[16 +: ID_W];
         awqos <= burst_q[24]; // [RL10]
         awcache <= burst_q[31:28]; // [RL17]
         awlock <= cmd[`DDH_B_LOCK]; // [RL16]
         write_autoprecharge_req <= cmd[`DDH_B_APC]; // [RL21]
         write_all_strobes_flag <= cmd[`DDH_B_ALLS];
         write_coherent_bufferable_sel <= cmd[`DDH_B_COBUF];
         wstrb <= cmd[`DDH_B_ALLS] ? '1 : {(DATA_W/256){strb_q}}; // [RL2]
      end
   end
   assign araddr = awaddr;
   assign arlen = awlen;
   assign arsize = awsize;
   assign arburst = awburst;
   assign arid = awid;
   assign arqos = awqos;
   assign arlock = awlock;
   assign read_autoprecharge_req = write_autoprecharge_req;

   // Status capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_n <= 1'b1;
         {done, id_err, last_err, rej} <= 4'h0;
         {bresp_q, rresp_q} <= 4'h0;
         tag_q <= '0;
         rsum <= 32'h0;
      end else begin
         busy_n <= next_state == DDH_IDLE;
         if (go)
            {done, id_err, last_err, rej} <= 4'h0;
         else begin
            done <= done || fin;
            rej <= rej || bad; // [RL9]
            id_err <= id_err || (b_hs && bid != awid) || (r_hs && rid != arid); // [RL3]
            last_err <= last_err || (r_hs && rlast != (beat == arlen)); // [RL7]
         end
         if (b_hs) begin
            bresp_q <= bresp; // [RL15]
            tag_q <= bid;
         end
         if (r_hs) begin
            rresp_q <= rresp; // [RL15]
            tag_q <= rid;
         end
         if (go_rd)
            rsum <= 32'h0;
         else if (r_hs)
            rsum <= rsum ^ fold;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence aw_wait; awvalid && !awready; endsequence
   sequence w_final; w_hs && wlast; endsequence
   aw_hold_a: assert property (aw_wait |=> awvalid && $stable(awaddr) && $stable(awlen)) // [RL20]
      else $error("write address dropped before ready");
   ar_hold_a: assert property (arvalid && !arready |=> arvalid && $stable(araddr)) // [RL20]
      else $error("read address dropped before ready");
   w_hold_a: assert property (wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wlast)) // [RL20]
      else $error("write data changed before ready");
   wlast_beat_a: assert property (wvalid |-> wlast == (beat == awlen)) // [RL8]
      else $error("write last on wrong beat");
   w_final_a: assert property (w_final |=> !wvalid ##0 bready) // [RL8]
      else $error("write data after last beat");
   alls_len_a: assert property (awvalid && write_all_strobes_flag |-> awlen <= 8'h0f) // [RL9]
      else $error("all strobes burst too long");
   burst_ok_a: assert property (awvalid || arvalid |-> awburst inside {2'b01, 2'b10}) // [RL4]
      else $error("illegal burst type issued");
   b_done_a: assert property (b_hs |=> !bready ##0 done) // [RL11]
      else $error("write response not completed");
   r_done_a: assert property (r_hs && rlast |=> !rready ##0 state == DDH_IDLE) // [RL12]
      else $error("read burst not closed");
   port_rst_a: assert property (!axi_aresetn |-> !awvalid && !arvalid && !wvalid) // [RL1]
      else $error("traffic while port held in reset");
   phy_clk_a: assert property (phy_half_rate_clock |=> !phy_half_rate_clock) // [RL19]
      else $error("phy clock not toggling");
   core_clk_a: assert property ($rose(controller_core_clock) |=> controller_core_clock ##1 !controller_core_clock) // [RL18]
      else $error("core clock not quarter rate");
endmodule

/* ddh_map.svh */
`ifndef DDH_MAP_SVH
`define DDH_MAP_SVH
`define DDH_CTRL 8'h00
`define DDH_ADDR_LO 8'h04
`define DDH_ADDR_HI 8'h08
`define DDH_BURST 8'h0c
`define DDH_STATUS 8'h10
`define DDH_SEED 8'h14
`define DDH_STRB 8'h18
`define DDH_RSUM 8'h1c
`define DDH_B_WR 0
`define DDH_B_RD 1
`define DDH_B_PRST 2
`define DDH_B_APC 3
`define DDH_B_ALLS 4
`define DDH_B_COBUF 5
`define DDH_B_LOCK 6
`define DDH_CTRL_RST 7'h00
`define DDH_BURST_RST 32'h0000_1600
`define DDH_ALLS_MAXLEN 8'h0f
`endif

/* ddh_pkg.sv */
package ddh_pkg;
   typedef logic [7:0] ddh_avaddr_t;
   typedef logic [32:0] ddh_axaddr_t;
   typedef enum logic [2:0] {
      DDH_IDLE = 3'b000,
      DDH_WADDR = 3'b001,
      DDH_WDATA = 3'b011,
      DDH_WRESP = 3'b010,
      DDH_RADDR = 3'b110,
      DDH_RDATA = 3'b111
   } ddh_state_t;
   typedef enum logic [1:0] {
      DDH_INCR = 2'b01,
      DDH_WRAP = 2'b10
   } ddh_burst_t;
endpackage

/* test_ddh_axi_host.sv */
`timescale 1ns/1ps
`include "ddh_map.svh"
module test_ddh_axi_host;
   import ddh_pkg::*;
   logic clk, nrst, avs_read, avs_write, avs_waitrequest, slow, bad_id, bad_last;
   ddh_avaddr_t avs_address;
   logic [31:0] avs_writedata, avs_readdata, seed, strb, rbase, q, x;
   logic controller_core_clock, phy_half_rate_clock, axi_aresetn;
   ddh_axaddr_t awaddr, araddr;
   logic [1:0] awburst, arburst, bresp, rresp, resp;
   logic [5:0] awid, arid, bid, rid;
   logic [7:0] awlen, arlen, c, p;
   logic [2:0] awsize, arsize;
   logic [3:0] awcache;
   logic awvalid, awready, awlock, awqos, write_autoprecharge_req, write_all_strobes_flag;
   logic write_coherent_bufferable_sel, wlast, wvalid, wready, bvalid, bready, arvalid, arready;
   logic arlock, arqos, read_autoprecharge_req, rlast, rvalid, rready;
   logic [511:0] wdata, rdata;
   logic [63:0] wstrb, awc, arc;
   logic [31:0] rb [3] = '{32'h0015_0602, 32'h0015_3602, 32'h0001_2610};
   logic [31:0] rc [3] = '{32'h01, 32'h02, 32'h11};
   int error_cnt, checks_done, merr, n, k;
   ddh_axi_host i_dut (.*);
   ddh_axi_dev i_dev (.*);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (awvalid && awready)
         awc <= {awaddr, awid, awlen, awsize, awburst, awcache, awqos, awlock, write_autoprecharge_req,
            write_coherent_bufferable_sel, write_all_strobes_flag};
      if (arvalid && arready)
         arc <= {araddr, arid, arlen, arsize, arburst, arqos, arlock, read_autoprecharge_req};
   end
   task automatic chk(input string s, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task report_and_stop;
      if (error_cnt == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input ddh_avaddr_t a, input logic [31:0] d);
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
      if (n >= 40) begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   task automatic run(input logic [31:0] b, input logic [31:0] cmd);
      bus(1'b1, `DDH_BURST, b);
      bus(1'b1, `DDH_CTRL, cmd);
      k = 0;
      do begin
         bus(1'b0, `DDH_STATUS, 32'h0);
         k++;
      end while (q[0] !== 1'b0 && k < 100);
      if (k >= 100) begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   initial begin
      {nrst, avs_read, avs_write, avs_address, avs_writedata, slow, bad_id, bad_last} = '0;
      {resp, seed, strb, rbase} = {2'b01, 32'h1000_0000, 32'ha5a5_0ff0, 32'h5a00_0000};
      error_cnt = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, `DDH_BURST, 32'h0);
      chk("burst_reset", q, 32'h0000_1600);
      bus(1'b0, `DDH_STRB, 32'h0);
      chk("strb_reset", q, 32'hffff_ffff);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(1'b1, `DDH_ADDR_LO, 32'h0000_1000);
      bus(1'b1, `DDH_ADDR_HI, 32'h1);
      bus(1'b1, `DDH_SEED, seed);
      bus(1'b1, `DDH_STRB, strb);
      run(32'h312a_1603, 32'h69);
      chk("aw", awc, {33'h1_0000_1000, 6'h2a, 8'h03, 3'h6, 2'b01, 4'h3, 5'b11110});
      chk("wr_status", q, 32'h0000_2a06);
      seed <= 32'h2000_0000;
      slow <= 1'b1;
      bus(1'b1, `DDH_SEED, 32'h2000_0000);
      run(32'h0001_260f, 32'h11);
      chk("alls_status", q, 32'h0000_0106);
      run(32'h0015_1602, 32'h0a);
      chk("ar", arc, {33'h1_0000_1000, 6'h15, 8'h02, 3'h6, 2'b01, 3'b001});
      chk("rd_status", q, 32'h0000_1516);
      x = 32'h0;
      for (int b = 0; b < 3; b++)
         for (int j = 0; j < 16; j++)
            x = x ^ rbase ^ {16'h0000, 8'(b), 8'(j)};
      bus(1'b0, `DDH_RSUM, 32'h0);
      chk("rsum", q, x);
      for (int i = 0; i < 3; i++) begin
         run(rb[i], rc[i]);
         chk("refused", q & 32'h0004_0001, 32'h0004_0000);
      end
      bad_id <= 1'b1;
      run(32'h0015_1602, 32'h02);
      chk("id_err", q[16], 1'b1);
      bad_id <= 1'b0;
      bad_last <= 1'b1;
      run(32'h0015_1602, 32'h02);
      chk("last_err", q[17], 1'b1);
      bad_last <= 1'b0;
      bus(1'b1, `DDH_CTRL, 32'h04);
      repeat (2) @(posedge clk);
      chk("port_reset", axi_aresetn, 1'b0);
      bus(1'b1, `DDH_CTRL, 32'h00);
      repeat (3) @(posedge clk);
      chk("port_release", axi_aresetn, 1'b1);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         c[i] = controller_core_clock;
         p[i] = phy_half_rate_clock;
      end
      chk("core_clock", c[7:2] ^ c[5:0], 6'h3f);
      chk("phy_clock", p[7:1] ^ p[6:0], 7'h7f);
      chk("far_side", merr, 0);
      report_and_stop();
   end
endmodule
